// ===== rtl/abscan_map.svh
// Offsets, cell positions, codes and reset values of the analog boundary-scan chain
`ifndef ABSCAN_MAP_SVH
`define ABSCAN_MAP_SVH

// Chain geometry
`define ABS_PIN_GROUPS    55
`define ABS_PORTA_PINS    8
`define ABS_ANA_CELLS     33
`define ABS_CHAIN_LEN     198
`define ABS_CHAIN_TOP     197

// Cell offsets inside a pin group
`define ABS_PIN_DATA      0
`define ABS_PIN_CTRL      1
`define ABS_PIN_PULLUP    2

// Analog cell offsets above the pin cells
`define ABS_A_CHSEL0      0
`define ABS_A_IREFEN      8
`define ABS_A_HOLD        9
`define ABS_A_GNDEN       10
`define ABS_A_EXTCH       11
`define ABS_A_DAC0        12
`define ABS_A_AMPEN       22
`define ABS_A_CONV_EN     23
`define ABS_A_CBGEN       24
`define ABS_A_PRIV        25
`define ABS_A_ACTEN       26
`define ABS_A_ACLK        27
`define ABS_A_COMP        28
`define ABS_A_BANDGAP     29
`define ABS_A_MUXSEL      30
`define ABS_A_RESULT      31
`define ABS_A_OFF         32

// Instruction codes, arbitrary values
`define ABS_IR_W          4
`define ABS_IR_EXTEST     4'h0
`define ABS_IR_SAMPLE     4'h2
`define ABS_IR_BYPASS     4'hf

// Register bus map
`define ABS_OFF_CTRL      4'h0
`define ABS_OFF_STATUS    4'h4
`define ABS_OFF_FIFO      4'h8
`define ABS_OFF_DAC       4'hc
`define ABS_CTRL_RESET    32'h0000_0000
`define ABS_CTRL_EN_BIT   0
`define ABS_CTRL_CLR_BIT  1
`define ABS_RESP_OKAY     2'h0
`define ABS_RESP_DECERR   2'h3

// Snapshot FIFO
`define ABS_FIFO_W        32
`define ABS_FIFO_D        16

`endif

// ===== rtl/abscan_pkg.sv
// Types shared by the analog boundary-scan chain
package abscan_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } abscan_tap_e;
endpackage

// ===== rtl/abscan_top.sv
// Analog boundary-scan chain with its TAP, snapshot FIFO and AXI4-Lite registers
// How it works
// - With scan selected, the 198-cell chain sits between tdi and tdo, top cell 197.
// - Cell 0 is least significant: first bit shifted in and first shifted out.
// - Analog control and observe cells take the most significant chain positions.
// - Pin groups follow pin-out order, so port A runs in reverse bit order.
// - Every pin gives three cells: output value, direction, then pull-up enable.
// - Port F pins 4 to 7 are the TAP pins and have no cells.
// - Comparator-off cell true switches the comparator off; idle value is 1.
// - Mux-select cell true routes converter mux to comparator; idle value is 0.
`include "abscan_map.svh"

module abscan_fifo #(
  parameter int W = `ABS_FIFO_W,
  parameter int D = `ABS_FIFO_D
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= wp_q + AW'(1);
      end
      if (pop)
        rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module abscan_top #(
  parameter int NPIN = `ABS_PIN_GROUPS
) (
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // Test access pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  // Pin cells, system side and pad side, in pin-out order
  input  wire logic [NPIN-1:0]   sys_out,
  input  wire logic [NPIN-1:0]   sys_dir,
  input  wire logic [NPIN-1:0]   sys_pullup,
  input  wire logic [NPIN-1:0]   pad_in,
  output logic [NPIN-1:0]        pad_out,
  output logic [NPIN-1:0]        pad_dir,
  output logic [NPIN-1:0]        pad_pullup,
  // Analog observe inputs
  input  wire logic              comparator_result_in,
  input  wire logic              converter_compare_in,
  // Analog control outputs
  output logic                   comparator_off_cell,
  output logic                   comparator_mux_select_cell,
  output logic                   comparator_bandgap_input_cell,
  output logic                   converter_enable_cell,
  output logic [7:0]             channel_select_cells,
  output logic                   precharge_cell,
  output logic                   hold_cell,
  output logic [9:0]             dac_cells,
  // AXI4-Lite write
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int PC  = 3 * NPIN; // TAP pins excluded
  localparam int LEN = PC + `ABS_ANA_CELLS;

  // Pin-out order puts port A highest bit first
  function automatic int pin_of_group(input int g);
    return (g < `ABS_PORTA_PINS) ? (`ABS_PORTA_PINS - 1 - g) : g;
  endfunction

  abscan_pkg::abscan_tap_e tap_q;
  abscan_pkg::abscan_tap_e tap_d;
  logic [2:0]            tck_q;
  logic [1:0]            tms_q;
  logic [1:0]            tdi_q;
  logic                  tck_rise;
  logic                  tck_fall;
  logic [LEN-1:0]        bsr_q;
  logic [LEN-1:0]        upd_q;
  logic [LEN-1:0]        cap_vec;
  logic [`ABS_IR_W-1:0]  ir_sh_q;
  logic [`ABS_IR_W-1:0]  ir_q;
  logic                  byp_q;
  logic                  scan_sel;
  logic                  extest;
  logic [31:0]           ctrl_q;
  logic                  en;
  logic                  ovf_q;
  logic                  snap_pend_q;
  logic [31:0]           snap_q;
  logic                  snap_ready;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [31:0]           fifo_data;
  logic [$clog2(`ABS_FIFO_D):0] fifo_level;
  logic                  aw_hold_q;
  logic                  w_hold_q;
  logic [3:0]            wr_addr_q;
  logic [31:0]           wr_data_q;
  logic [3:0]            wr_strb_q;
  logic                  wr_go;

  assign en       = ctrl_q[`ABS_CTRL_EN_BIT];
  assign tck_rise = tck_q[1] & ~tck_q[2];
  assign tck_fall = ~tck_q[1] & tck_q[2];
  assign scan_sel = (ir_q == `ABS_IR_EXTEST) || (ir_q == `ABS_IR_SAMPLE);
  assign extest   = (ir_q == `ABS_IR_EXTEST) && en;

  // Test access pins pass two flops before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tck_q <= '0;
      tms_q <= '1;
      tdi_q <= '0;
    end
    else if (ce)
    begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  end

  always_comb
  begin
    case (tap_q)
      abscan_pkg::TLR:    tap_d = tms_q[1] ? abscan_pkg::TLR    : abscan_pkg::RTI;
      abscan_pkg::RTI:    tap_d = tms_q[1] ? abscan_pkg::SEL_DR : abscan_pkg::RTI;
      abscan_pkg::SEL_DR: tap_d = tms_q[1] ? abscan_pkg::SEL_IR : abscan_pkg::CAP_DR;
      abscan_pkg::CAP_DR: tap_d = tms_q[1] ? abscan_pkg::EX1_DR : abscan_pkg::SH_DR;
      abscan_pkg::SH_DR:  tap_d = tms_q[1] ? abscan_pkg::EX1_DR : abscan_pkg::SH_DR;
      abscan_pkg::EX1_DR: tap_d = tms_q[1] ? abscan_pkg::UPD_DR : abscan_pkg::PA_DR;
      abscan_pkg::PA_DR:  tap_d = tms_q[1] ? abscan_pkg::EX2_DR : abscan_pkg::PA_DR;
      abscan_pkg::EX2_DR: tap_d = tms_q[1] ? abscan_pkg::UPD_DR : abscan_pkg::SH_DR;
      abscan_pkg::UPD_DR: tap_d = tms_q[1] ? abscan_pkg::SEL_DR : abscan_pkg::RTI;
      abscan_pkg::SEL_IR: tap_d = tms_q[1] ? abscan_pkg::TLR    : abscan_pkg::CAP_IR;
      abscan_pkg::CAP_IR: tap_d = tms_q[1] ? abscan_pkg::EX1_IR : abscan_pkg::SH_IR;
      abscan_pkg::SH_IR:  tap_d = tms_q[1] ? abscan_pkg::EX1_IR : abscan_pkg::SH_IR;
      abscan_pkg::EX1_IR: tap_d = tms_q[1] ? abscan_pkg::UPD_IR : abscan_pkg::PA_IR;
      abscan_pkg::PA_IR:  tap_d = tms_q[1] ? abscan_pkg::EX2_IR : abscan_pkg::PA_IR;
      abscan_pkg::EX2_IR: tap_d = tms_q[1] ? abscan_pkg::UPD_IR : abscan_pkg::SH_IR;
      abscan_pkg::UPD_IR: tap_d = tms_q[1] ? abscan_pkg::SEL_DR : abscan_pkg::RTI;
      default:            tap_d = abscan_pkg::TLR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || (ce && !en))
      tap_q <= abscan_pkg::TLR;
    else if (ce && tck_rise)
      tap_q <= tap_d;
  end

  // Instruction register
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (ce && !en))
    begin
      ir_sh_q <= '0;
      ir_q    <= `ABS_IR_BYPASS;
    end
    else if (ce && tck_rise)
    begin
      case (tap_q)
        abscan_pkg::TLR:    ir_q    <= `ABS_IR_BYPASS;
        abscan_pkg::CAP_IR: ir_sh_q <= `ABS_IR_W'(1);
        abscan_pkg::SH_IR:  ir_sh_q <= {tdi_q[1], ir_sh_q[`ABS_IR_W-1:1]};
        abscan_pkg::UPD_IR: ir_q    <= ir_sh_q;
        default:            ir_q    <= ir_q;
      endcase
    end
  end

  // Capture vector: pins from the system or pad, analog control cells hold update state, the COMP and RESULT cells take the analog inputs
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      localparam int P = pin_of_group(g);
      // Three cells per pin group: value, direction, pull-up
      assign cap_vec[3*g + `ABS_PIN_DATA]   = sys_dir[P] ? sys_out[P] : pad_in[P];
      assign cap_vec[3*g + `ABS_PIN_CTRL]   = sys_dir[P];
      assign cap_vec[3*g + `ABS_PIN_PULLUP] = sys_pullup[P];
    end
  endgenerate

  // Analog cells sit above every pin cell
  always_comb
  begin
    cap_vec[LEN-1:PC] = upd_q[LEN-1:PC];
    cap_vec[PC + `ABS_A_COMP]   = converter_compare_in;
    cap_vec[PC + `ABS_A_RESULT] = comparator_result_in;
  end

  // Boundary register: tdi enters at the top, cell 0 leaves first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bsr_q <= '0;
      byp_q <= 1'b0;
    end
    else if (ce && tck_rise && scan_sel)
    begin
      if (tap_q == abscan_pkg::CAP_DR)
        bsr_q <= cap_vec;
      else if (tap_q == abscan_pkg::SH_DR)
        bsr_q <= {tdi_q[1], bsr_q[LEN-1:1]};
    end
    else if (ce && tck_rise && tap_q == abscan_pkg::SH_DR)
      byp_q <= tdi_q[1];
    else if (ce && tck_rise && tap_q == abscan_pkg::CAP_DR)
      byp_q <= 1'b0;
  end

  // Update latches, idle to safe analog values
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upd_q                      <= '0;
      upd_q[PC + `ABS_A_OFF]     <= 1'b1;
      upd_q[PC + `ABS_A_MUXSEL]  <= 1'b0;
    end
    else if (ce && tck_rise && scan_sel && tap_q == abscan_pkg::UPD_DR)
      upd_q <= bsr_q;
  end

  // Tdo changes on the falling test clock edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tdo    <= 1'b1;
      tdo_oe <= 1'b0;
    end
    else if (ce && tck_fall)
    begin
      tdo    <= (tap_q == abscan_pkg::SH_IR) ? ir_sh_q[0] :
                scan_sel ? bsr_q[0] : byp_q;
      tdo_oe <= en && (tap_q == abscan_pkg::SH_IR || tap_q == abscan_pkg::SH_DR);
    end
  end

  // Pad and analog drivers: update cells under external test, else system values for pads and idle values for analog cells
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_drv
      localparam int P = pin_of_group(g);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pad_out[P]    <= 1'b0;
          pad_dir[P]    <= 1'b0;
          pad_pullup[P] <= 1'b0;
        end
        else if (ce)
        begin
          pad_out[P]    <= extest ? upd_q[3*g + `ABS_PIN_DATA]   : sys_out[P];
          pad_dir[P]    <= extest ? upd_q[3*g + `ABS_PIN_CTRL]   : sys_dir[P];
          pad_pullup[P] <= extest ? upd_q[3*g + `ABS_PIN_PULLUP] : sys_pullup[P];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comparator_off_cell           <= 1'b1;
      comparator_mux_select_cell    <= 1'b0;
      comparator_bandgap_input_cell <= 1'b0;
      converter_enable_cell         <= 1'b0;
      channel_select_cells          <= '0;
      precharge_cell                <= 1'b0;
      hold_cell                     <= 1'b0;
      dac_cells                     <= '0;
    end
    else if (ce)
    begin
      comparator_off_cell        <= extest ? upd_q[PC + `ABS_A_OFF] : 1'b1;
      comparator_mux_select_cell <= extest & upd_q[PC + `ABS_A_MUXSEL];
      comparator_bandgap_input_cell <= extest & upd_q[PC + `ABS_A_BANDGAP];
      converter_enable_cell      <= extest & upd_q[PC + `ABS_A_CONV_EN];
      channel_select_cells       <= extest ? upd_q[PC + `ABS_A_CHSEL0 +: 8] : 8'h00;
      precharge_cell             <= extest & upd_q[PC + `ABS_A_ACLK - 16];
      hold_cell                  <= extest & upd_q[PC + `ABS_A_HOLD];
      dac_cells                  <= extest ? upd_q[PC + `ABS_A_DAC0 +: 10] : 10'h000;
    end
  end

  // Snapshot of the top 32 chain cells after each update, held until FIFO takes it or the next update overwrites it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      snap_pend_q <= 1'b0;
      snap_q      <= '0;
      ovf_q       <= 1'b0;
    end
    else if (ce)
    begin
      if (tck_rise && scan_sel && tap_q == abscan_pkg::UPD_DR)
      begin
        snap_q      <= bsr_q[LEN-1 -: 32];
        snap_pend_q <= 1'b1;
        if (snap_pend_q && !snap_ready)
          ovf_q <= 1'b1;
      end
      else if (snap_ready)
        snap_pend_q <= 1'b0;
      if (wr_go && wr_addr_q == `ABS_OFF_CTRL && wr_data_q[`ABS_CTRL_CLR_BIT] &&
          !(tck_rise && scan_sel && tap_q == abscan_pkg::UPD_DR && snap_pend_q))
        ovf_q <= 1'b0;
    end
  end

  abscan_fifo #(.W(`ABS_FIFO_W), .D(`ABS_FIFO_D)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (snap_pend_q),
    .in_ready  (snap_ready),
    .in_data   (snap_q),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // AXI4-Lite slave
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go         = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign fifo_pop      = ce & s_axi_arvalid & s_axi_arready & (s_axi_araddr == `ABS_OFF_FIFO);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      wr_addr_q    <= '0;
      wr_data_q    <= '0;
      wr_strb_q    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ABS_RESP_OKAY;
      ctrl_q       <= `ABS_CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q  <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_q == `ABS_OFF_CTRL) ? `ABS_RESP_OKAY : `ABS_RESP_DECERR;
        if (wr_addr_q == `ABS_OFF_CTRL && wr_strb_q[0])
          ctrl_q[0] <= wr_data_q[`ABS_CTRL_EN_BIT];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `ABS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ABS_RESP_OKAY;
        case (s_axi_araddr)
          `ABS_OFF_CTRL:   s_axi_rdata <= ctrl_q;
          `ABS_OFF_STATUS: s_axi_rdata <= {15'h0, ovf_q, 3'h0, fifo_level,
                                           ir_q, tap_q}; 
          `ABS_OFF_FIFO:   s_axi_rdata <= fifo_valid ? fifo_data : 32'h0000_0000;
          `ABS_OFF_DAC:    s_axi_rdata <= {22'h0, upd_q[PC + `ABS_A_DAC0 +: 10]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ABS_RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== test/abscan_tap_model.sv
// Test controller model that walks the TAP and shifts the chain
`include "abscan_map.svh"
module abscan_tap_model (
  // Launch alignment
  input  wire logic aclk,
  // Test access pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int      N    = `ABS_CHAIN_LEN;
  localparam realtime HALF = 62.5;  // 125 ns TCK, far above five chains per hold time
  initial {tck, tms, tdi} = 3'b010;
  // Offset keeps TCK edges off the system clock edges
  task automatic start;
    @(posedge aclk);
    #1.3;
  endtask
  task automatic step(input logic m, input logic d, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #HALF;
    o = tdo;
    tck = 1'b1;
    #HALF;
    tdi = !d;  // Stale data never looks valid between bits
  endtask
  task automatic walk(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(m[i], 1'b0, o);
  endtask
  task automatic reset_tap;
    start();
    walk(8'h1f, 6);
  endtask
  // Instruction is always loaded before the step's data
  task automatic load_ir(input logic [3:0] code, output logic [3:0] cap);
    start();
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) step(i == 3, code[i], cap[i]);
    walk(8'h01, 2);
  endtask
  // Result is read from the bits shifted out while the step shifts
  task automatic shift_dr(input logic [N-1:0] din, output logic [N-1:0] dout);
    start();
    walk(8'h01, 3);
    for (int i = 0; i < N; i++) step(i == N - 1, din[i], dout[i]);
    walk(8'h01, 2);
  endtask
endmodule

// ===== test/abscan_top_properties.sv
// Port-level checks of the analog boundary-scan top
module abscan_top_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Test access and analog cells
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic        comparator_off_cell,
  input wire logic        comparator_mux_select_cell,
  input wire logic        hold_cell,
  input wire logic [9:0]  dac_cells,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_LAT: assert property (s_wr_both |-> ##2 s_axi_bvalid) else $error("late bvalid");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_RD_LAT: assert property (s_rd_take |=> s_axi_rvalid) else $error("late rvalid");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_IDLE_RESET: assert property (disable iff (1'b0) !aresetn |=> comparator_off_cell
    && !comparator_mux_select_cell && !tdo_oe) else $error("idle analog values wrong in reset");
  AST_UPD_TCK: assert property ($changed(dac_cells) || $changed(hold_cell) |-> tck)
    else $error("update cells moved without tck high");
  AST_TDO_FALL: assert property (tdo_oe && $changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
endmodule

bind abscan_top abscan_top_chk u_chk (.aclk, .aresetn, .tck, .tdo, .tdo_oe, .comparator_off_cell,
  .comparator_mux_select_cell, .hold_cell, .dac_cells, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ===== test/tb.sv
// Self-checking bench for the analog boundary-scan chain
`include "abscan_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          N      = `ABS_CHAIN_LEN;
  localparam int          B      = 3 * `ABS_PIN_GROUPS;
  localparam logic [9:0]  VIN    = 10'h133;
  localparam logic [11:0] HOLD_T = 12'hf7a;
  localparam logic [11:0] PRE_T  = 12'hbde;
  logic         aclk, aresetn, ce, tck, tms, tdi, tdo, precharge_cell_q;
  logic         comparator_result_in, converter_compare_in, comparator_off_cell;
  logic         comparator_mux_select_cell, comparator_bandgap_input_cell;
  logic         converter_enable_cell, precharge_cell, hold_cell;
  logic [7:0]   channel_select_cells;
  logic [9:0]   dac_cells;
  logic [54:0]  sys_out, sys_dir, sys_pullup, pad_in, pad_out, pad_dir, pad_pullup;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cap;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [N-1:0] q, x;
  logic [31:0]  snaps[$];
  int           err_total, n_compared;

  abscan_top u_abscan_top (
    .aclk, .aresetn, .ce, .tck, .tms, .tdi, .tdo, .tdo_oe(), .sys_out, .sys_dir, .sys_pullup,
    .pad_in, .pad_out, .pad_dir, .pad_pullup, .comparator_result_in, .converter_compare_in,
    .comparator_off_cell, .comparator_mux_select_cell, .comparator_bandgap_input_cell,
    .converter_enable_cell, .channel_select_cells, .precharge_cell, .hold_cell, .dac_cells,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  abscan_tap_model ctl (.aclk, .tck, .tms, .tdi, .tdo);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Converter model: compare result settles when precharge drops
  always @(posedge aclk)
  begin
    precharge_cell_q <= precharge_cell;
    if (precharge_cell_q && !precharge_cell)
      converter_compare_in <= dac_cells > VIN;
  end

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {aw, w} = 2'b00;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw || (s_axi_awvalid && s_axi_awready);
      w = w || (s_axi_wvalid && s_axi_wready);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, ed});
  endtask
  function automatic logic [N-1:0] mk(logic [9:0] d, logic h, logic p, logic off, logic mux);
    logic [N-1:0] v;
    v = '0;
    v[B+`ABS_A_CONV_EN] = 1'b1;
    v[B+`ABS_A_DAC0 +: 10] = d;
    v[B+`ABS_A_CHSEL0 +: 8] = 8'h08;
    {v[B+`ABS_A_HOLD], v[B+`ABS_A_EXTCH]} = {h, p};
    {v[B+`ABS_A_OFF], v[B+`ABS_A_MUXSEL]} = {off, mux};
    return v;
  endfunction
  function automatic logic [2:0] pin_cells(int g);
    int p;
    p = (g < `ABS_PORTA_PINS) ? `ABS_PORTA_PINS - 1 - g : g;
    return {sys_pullup[p], sys_dir[p], sys_dir[p] ? sys_out[p] : pad_in[p]};
  endfunction
  function automatic logic [31:0] st(logic [4:0] lvl, logic ovf);
    return {15'h0, ovf, 3'h0, lvl, `ABS_IR_EXTEST, 4'(abscan_pkg::RTI)};
  endfunction
  task automatic sdr(input logic [N-1:0] v);
    ctl.shift_dr(v, q);
    if (snaps.size() < `ABS_FIFO_D)
      snaps.push_back(v[N-1 -: 32]);
  endtask

  initial
  begin
    logic [9:0] d;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, precharge_cell_q} = '0;
    {ce, converter_compare_in, comparator_result_in} = 3'b111;
    s_axi_wstrb = 4'hf;
    sys_out = 55'h12_3456_789a_bc01;
    sys_dir = 55'h5a_0f0f_00ff_33c3;
    sys_pullup = 55'h01_8421_8421_c350;
    pad_in = 55'h7f_edcb_a987_6543;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({comparator_off_cell, comparator_mux_select_cell}, 2'b10);
    rd(`ABS_OFF_CTRL, `ABS_CTRL_RESET, `ABS_RESP_OKAY);
    rd(4'h2, 32'h0, `ABS_RESP_DECERR);
    wr(4'h6, 32'h1, `ABS_RESP_DECERR);
    wr(`ABS_OFF_CTRL, 32'h1, `ABS_RESP_OKAY);
    rd(`ABS_OFF_CTRL, 32'h1, `ABS_RESP_OKAY);
    ctl.reset_tap();
    ctl.load_ir(`ABS_IR_SAMPLE, cap);
    chk(cap, 4'h1);
    sdr(mk(10'h200, 1'b1, 1'b1, 1'b1, 1'b0));
    for (int g = 0; g < `ABS_PIN_GROUPS; g++) chk(q[3*g +: 3], pin_cells(g));
    chk(q[B+`ABS_A_RESULT], 1'b1);
    ctl.load_ir(`ABS_IR_EXTEST, cap);
    for (int s = 2; s <= 11; s++)
    begin
      d = (s == 4 || s == 5) ? 10'h123 : (s == 9 || s == 10) ? 10'h143 : 10'h200;
      sdr(mk(d, HOLD_T[s], PRE_T[s], 1'b1, 1'b0));
      if (s == 6 || s == 11)
        chk(q[B+`ABS_A_COMP], s == 11);
      chk({hold_cell, precharge_cell, dac_cells}, {HOLD_T[s], PRE_T[s], d});
      chk({converter_enable_cell, channel_select_cells}, 9'h108);
      chk({comparator_off_cell, comparator_mux_select_cell, pad_out}, {2'b10, 55'h0});
    end
    x = mk(10'h3ff, 1'b0, 1'b0, 1'b0, 1'b1);
    {x[B+`ABS_A_BANDGAP], x[0], x[25], x[29]} = 4'hf;
    repeat (7) sdr(x);
    chk({comparator_off_cell, comparator_mux_select_cell, comparator_bandgap_input_cell}, 3'b011);
    chk({pad_out, pad_dir, pad_pullup}, {55'h80, 55'h100, 55'h200});
    rd(`ABS_OFF_STATUS, st(5'h10, 1'b1), `ABS_RESP_OKAY);
    repeat (`ABS_FIFO_D) rd(`ABS_OFF_FIFO, snaps.pop_front(), `ABS_RESP_OKAY);
    rd(`ABS_OFF_FIFO, x[N-1 -: 32], `ABS_RESP_OKAY);
    rd(`ABS_OFF_FIFO, 32'h0, `ABS_RESP_OKAY);
    rd(`ABS_OFF_STATUS, st(5'h0, 1'b1), `ABS_RESP_OKAY);
    wr(`ABS_OFF_CTRL, 32'h3, `ABS_RESP_OKAY);
    rd(`ABS_OFF_STATUS, st(5'h0, 1'b0), `ABS_RESP_OKAY);
    final_report();
  end

  initial
  begin
    repeat (90000) @(posedge aclk);
    err_total++;
    final_report();
  end
endmodule
